// >>> cwt_pkg.sv
package cwt_pkg;

  // register offsets
  localparam logic [6:0] ADDR_WAKE_FILTER = 7'h09;
  localparam logic [6:0] ADDR_TIMER_A     = 7'h0C;
  localparam logic [6:0] ADDR_TIMER_B     = 7'h0D;
  localparam logic [6:0] ADDR_SHUTDOWN    = 7'h10;

  // writable bits and reset value
  localparam logic [7:0] FILTER_MASK   = 8'h3F;
  localparam logic [7:0] TIMER_MASK    = 8'h77;
  localparam logic [7:0] SHUTDOWN_MASK = 8'h70;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // field positions
  localparam int FLT_WIDTH   = 2;
  localparam int TMR_ON_LSB  = 4;
  localparam int TMR_PER_LSB = 0;
  localparam int SD_OV_BIT   = 6;
  localparam int SD_UV_BIT   = 5;
  localparam int SD_REC_BIT  = 4;
  localparam int HS_CODE_W   = 3;

  // codes
  localparam logic [1:0] FLT_STATIC_16 = 2'h0;
  localparam logic [1:0] FLT_STATIC_64 = 2'h1;
  localparam logic [2:0] ON_STOP_LOW   = 3'h0;
  localparam logic [2:0] ON_STOP_HIGH  = 3'h6;
  localparam logic [2:0] HS_ON         = 3'h1;
  localparam logic [2:0] HS_TIMER_A    = 3'h2;
  localparam logic [2:0] HS_TIMER_B    = 3'h3;
  localparam logic [2:0] HS_PWM_A      = 3'h4;
  localparam logic [2:0] HS_PWM_B      = 3'h5;

  // timing
  localparam int CLK_MHZ      = 50;
  localparam int FLT_SHORT_US = 16;
  localparam int FLT_LONG_US  = 64;
  localparam int FLT_SHORT_CYCLES = FLT_SHORT_US * CLK_MHZ;
  localparam int FLT_LONG_CYCLES  = FLT_LONG_US * CLK_MHZ;
  localparam int TICK_US      = 100;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;
  localparam int US_PER_MS    = 1000;

  typedef struct packed {
    logic [2:0] on_time;
    logic [2:0] period;
  } timer_cfg_s;

  typedef struct packed {
    logic level;
    logic period_start;
    logic on_end;
  } timer_evt_s;

  // on-time in ticks; zero means the timer does not run
  function automatic logic [14:0] on_ticks(input logic [2:0] code);
    case (code)
      3'h1:    on_ticks = 15'(100 / TICK_US);
      3'h2:    on_ticks = 15'(300 / TICK_US);
      3'h3:    on_ticks = 15'(1000 / TICK_US);
      3'h4:    on_ticks = 15'(10000 / TICK_US);
      3'h5:    on_ticks = 15'(20000 / TICK_US);
      default: on_ticks = 15'h0;
    endcase
  endfunction

  // period in ticks; zero for the reserved code
  function automatic logic [14:0] period_ticks(input logic [2:0] code);
    case (code)
      3'h0:    period_ticks = 15'(10 * US_PER_MS / TICK_US);
      3'h1:    period_ticks = 15'(20 * US_PER_MS / TICK_US);
      3'h2:    period_ticks = 15'(50 * US_PER_MS / TICK_US);
      3'h3:    period_ticks = 15'(100 * US_PER_MS / TICK_US);
      3'h4:    period_ticks = 15'(200 * US_PER_MS / TICK_US);
      3'h5:    period_ticks = 15'(1000 * US_PER_MS / TICK_US);
      3'h6:    period_ticks = 15'(2000 * US_PER_MS / TICK_US);
      default: period_ticks = 15'h0;
    endcase
  endfunction

endpackage

// >>> cyclic_timer.sv
`timescale 1ns/1ps
module cyclic_timer (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  // control
  input  wire logic               tick_i,
  input  cwt_pkg::timer_cfg_s     cfg_i,
  input  wire logic               assigned_i,
  // events
  output cwt_pkg::timer_evt_s     evt_o
);

  logic [14:0]         cnt_q, cnt_d, on_len, per_len;
  logic                run_q, run_d;
  cwt_pkg::timer_evt_s evt_q, evt_d;

  always_comb
  begin
    on_len  = cwt_pkg::on_ticks(cfg_i.on_time);
    per_len = cwt_pkg::period_ticks(cfg_i.period);
    run_d   = assigned_i && (on_len != 15'h0) && (per_len != 15'h0);
    cnt_d   = cnt_q;
    evt_d   = '0;
    // wrap on >= so that shrinking the period mid-run cannot overrun
    if (!run_d)
      cnt_d = 15'h0;
    else if (run_q && tick_i)
      cnt_d = (cnt_q >= per_len - 15'h1) ? 15'h0 : cnt_q + 15'h1;
    evt_d.period_start = run_d && (!run_q || (tick_i && cnt_q >= per_len - 15'h1));
    evt_d.on_end = run_q && run_d && tick_i && (cnt_q == on_len - 15'h1);
    evt_d.level  = (cfg_i.on_time == cwt_pkg::ON_STOP_HIGH)
                 || (run_d && cnt_d < on_len);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 15'h0;
      run_q <= 1'b0;
      evt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      evt_q <= evt_d;
    end
  end

  assign evt_o = evt_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_stop_low_out: assert property (cfg_i.on_time == cwt_pkg::ON_STOP_LOW |=> !evt_o.level)
    else $error("stopped-low timer drives high");
  chk_stop_high_out: assert property (cfg_i.on_time == cwt_pkg::ON_STOP_HIGH |=> evt_o.level)
    else $error("stopped-high timer drives low");
  chk_unassigned_idle: assert property (!assigned_i |=> !evt_o.period_start)
    else $error("unassigned timer started a period");
  chk_period_starts_high: assert property (evt_o.period_start |-> evt_o.level)
    else $error("period started with output low");
  chk_on_end_drops: assert property (evt_o.on_end && !$past(cfg_i.on_time == cwt_pkg::ON_STOP_HIGH)
    && $past(cwt_pkg::on_ticks(cfg_i.on_time) < cwt_pkg::period_ticks(cfg_i.period))
    |-> !evt_o.level)
    else $error("output still high after on-time end");

endmodule

// >>> wake_filter.sv
`timescale 1ns/1ps
module wake_filter (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // input and mode
  input  wire logic       level_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       sample_a_i,
  input  wire logic       sample_b_i,
  // filtered level
  output logic            level_o
);

  logic [11:0] cnt_q, cnt_d;
  logic        prev_q, prev_d, lvl_q, lvl_d, sample;
  logic [11:0] thr;

  always_comb
  begin
    prev_d = level_i;
    cnt_d  = (level_i != prev_q) ? 12'h0 : (cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'h1;
    thr    = (mode_i == cwt_pkg::FLT_STATIC_64) ? 12'(cwt_pkg::FLT_LONG_CYCLES)
                                                : 12'(cwt_pkg::FLT_SHORT_CYCLES);
    sample = mode_i[0] ? sample_b_i : sample_a_i;
    lvl_d  = lvl_q;
    if (!mode_i[1] && cnt_q >= thr)
      lvl_d = prev_q;
    else if (mode_i[1] && sample && cnt_q >= 12'(cwt_pkg::FLT_SHORT_CYCLES))
      lvl_d = prev_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q  <= 12'h0;
      prev_q <= 1'b0;
      lvl_q  <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      prev_q <= prev_d;
      lvl_q  <= lvl_d;
    end
  end

  assign level_o = lvl_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_static_short: assert property (mode_i == cwt_pkg::FLT_STATIC_16 && level_i != level_o
    && !$stable(level_i) ##1 (level_i == $past(level_i)) [*8] |-> level_o != level_i)
    else $error("static filter passed a short pulse");
  chk_cyclic_hold: assert property (mode_i == 2'h2 && !sample_a_i |=> $stable(level_o))
    else $error("cyclic filter changed outside a sample");
  chk_cyclic_b_hold: assert property (mode_i == 2'h3 && !sample_b_i |=> $stable(level_o))
    else $error("cyclic filter changed outside a sample");

endmodule

// >>> cyclic_sense_timer_wake_filter.sv
`timescale 1ns/1ps
module cyclic_sense_timer_wake_filter #(
  parameter int TICK_CYCLES = cwt_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        soft_rst_i,
  // register port
  input  wire logic        reg_wr_i,
  input  wire logic [6:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // switch control context
  input  wire logic [11:0] hs_cfg_i,
  input  wire logic        hs_cfg_wr_i,
  input  wire logic [1:0]  pwm_i,
  input  wire logic        restart_mode_i,
  input  wire logic        hs_clear_i,
  input  wire logic [1:0]  timer_wake_en_i,
  // pins
  input  wire logic [2:0]  wake_pin_i,
  input  wire logic        supply_ov_i,
  input  wire logic        supply_uv_i,
  // results
  output logic      [3:0]  high_side_output_o,
  output logic      [1:0]  timer_level_o,
  output logic      [1:0]  timer_wake_o,
  output logic      [2:0]  wake_level_o,
  output logic             supply_shutdown_o
);

  // registers
  logic [7:0] wake_filter_select_q, wake_filter_select_d;
  logic [7:0] cyclic_timer_a_control_q, cyclic_timer_a_control_d;
  logic [7:0] cyclic_timer_b_control_q, cyclic_timer_b_control_d;
  logic [7:0] switch_supply_shutdown_control_q, switch_supply_shutdown_control_d;
  logic [7:0] rdata_q, rdata_d;

  logic [1:0] assigned, restart_clr;
  logic       wr_filter, wr_timer_a, wr_timer_b, wr_shutdown;

  // which timers drive at least one switch
  always_comb
  begin
    assigned = 2'b00;
    for (int s = 0; s < 4; s++)
    begin
      if (hs_cfg_i[s*cwt_pkg::HS_CODE_W +: cwt_pkg::HS_CODE_W] == cwt_pkg::HS_TIMER_A)
        assigned[0] = 1'b1;
      if (hs_cfg_i[s*cwt_pkg::HS_CODE_W +: cwt_pkg::HS_CODE_W] == cwt_pkg::HS_TIMER_B)
        assigned[1] = 1'b1;
    end
  end

  always_comb
  begin
    wr_filter   = reg_wr_i && reg_addr_i == cwt_pkg::ADDR_WAKE_FILTER;
    wr_timer_a  = reg_wr_i && reg_addr_i == cwt_pkg::ADDR_TIMER_A;
    wr_timer_b  = reg_wr_i && reg_addr_i == cwt_pkg::ADDR_TIMER_B;
    wr_shutdown = reg_wr_i && reg_addr_i == cwt_pkg::ADDR_SHUTDOWN;
    // cyclic sense only counts when a switch uses the timer
    restart_clr = {2{restart_mode_i && hs_clear_i}} & assigned;
    wake_filter_select_d             = wake_filter_select_q;
    cyclic_timer_a_control_d         = cyclic_timer_a_control_q;
    cyclic_timer_b_control_d         = cyclic_timer_b_control_q;
    switch_supply_shutdown_control_d = switch_supply_shutdown_control_q;
    if (soft_rst_i)
    begin
      wake_filter_select_d             = cwt_pkg::REG_RESET;
      cyclic_timer_a_control_d         = cwt_pkg::REG_RESET;
      cyclic_timer_b_control_d         = cwt_pkg::REG_RESET;
      switch_supply_shutdown_control_d = cwt_pkg::REG_RESET;
    end
    else
    begin
      if (wr_filter)
        wake_filter_select_d = reg_wdata_i & cwt_pkg::FILTER_MASK;
      if (wr_timer_a)
        cyclic_timer_a_control_d = reg_wdata_i & cwt_pkg::TIMER_MASK;
      if (wr_timer_b)
        cyclic_timer_b_control_d = reg_wdata_i & cwt_pkg::TIMER_MASK;
      if (wr_shutdown)
        switch_supply_shutdown_control_d = reg_wdata_i & cwt_pkg::SHUTDOWN_MASK;
      // the hardware clear beats a write landing in the same cycle
      if (restart_clr[0])
        cyclic_timer_a_control_d = cwt_pkg::REG_RESET;
      if (restart_clr[1])
        cyclic_timer_b_control_d = cwt_pkg::REG_RESET;
    end
    unique case (reg_addr_i)
      cwt_pkg::ADDR_WAKE_FILTER: rdata_d = wake_filter_select_q;
      cwt_pkg::ADDR_TIMER_A:     rdata_d = cyclic_timer_a_control_q;
      cwt_pkg::ADDR_TIMER_B:     rdata_d = cyclic_timer_b_control_q;
      cwt_pkg::ADDR_SHUTDOWN:    rdata_d = switch_supply_shutdown_control_q;
      default:                   rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_filter_select_q             <= cwt_pkg::REG_RESET;
      cyclic_timer_a_control_q         <= cwt_pkg::REG_RESET;
      cyclic_timer_b_control_q         <= cwt_pkg::REG_RESET;
      switch_supply_shutdown_control_q <= cwt_pkg::REG_RESET;
      rdata_q                          <= 8'h00;
    end
    else
    begin
      wake_filter_select_q             <= wake_filter_select_d;
      cyclic_timer_a_control_q         <= cyclic_timer_a_control_d;
      cyclic_timer_b_control_q         <= cyclic_timer_b_control_d;
      switch_supply_shutdown_control_q <= switch_supply_shutdown_control_d;
      rdata_q                          <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // pin synchronisers: a change counts once stages two and three agree
  logic [4:0] sy1_q, sy2_q, sy3_q, pin_q, pin_d, pins;

  always_comb
  begin
    pins  = {supply_uv_i, supply_ov_i, wake_pin_i};
    pin_d = pin_q;
    for (int b = 0; b < 5; b++)
      if (sy2_q[b] == sy3_q[b])
        pin_d[b] = sy3_q[b];
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
      sy3_q <= 5'h00;
      pin_q <= 5'h00;
    end
    else
    begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      pin_q <= pin_d;
    end
  end

  // timebase; timers count in these ticks so their counters stay narrow
  logic [15:0] pre_q, pre_d;
  logic        tick_q, tick_d;

  always_comb
  begin
    tick_d = (pre_q == 16'(TICK_CYCLES - 1));
    pre_d  = tick_d ? 16'h0000 : pre_q + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // two timers, same encoding
  cwt_pkg::timer_cfg_s tcfg [2];
  cwt_pkg::timer_evt_s tevt [2];

  assign tcfg[0] = {cyclic_timer_a_control_q[cwt_pkg::TMR_ON_LSB +: 3],
                    cyclic_timer_a_control_q[cwt_pkg::TMR_PER_LSB +: 3]};
  assign tcfg[1] = {cyclic_timer_b_control_q[cwt_pkg::TMR_ON_LSB +: 3],
                    cyclic_timer_b_control_q[cwt_pkg::TMR_PER_LSB +: 3]};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_timer
      cyclic_timer u_timer (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .tick_i     (tick_q),
        .cfg_i      (tcfg[g]),
        .assigned_i (assigned[g]),
        .evt_o      (tevt[g])
      );
      assign timer_level_o[g] = tevt[g].level;
    end
    // a cyclic mode samples only while its timer drives a switch
    for (g = 0; g < 3; g++)
    begin : g_wake
      wake_filter u_filter (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .level_i    (pin_q[g]),
        .mode_i     (wake_filter_select_q[g*cwt_pkg::FLT_WIDTH +: cwt_pkg::FLT_WIDTH]),
        .sample_a_i (tevt[0].on_end),
        .sample_b_i (tevt[1].on_end),
        .level_o    (wake_level_o[g])
      );
    end
  endgenerate

  // cyclic wake runs off the period start of the same timers whose on-time end sensing samples
  logic [1:0] twake_q, twake_d;

  always_comb
    twake_d = {tevt[1].period_start, tevt[0].period_start} & timer_wake_en_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      twake_q <= 2'b00;
    else
      twake_q <= twake_d;
  end

  assign timer_wake_o = twake_q;

  // supply fault shutdown and recovery
  logic [3:0] hs_q, hs_d, demand;
  logic       fault, fault_q, latch_q, latch_d;
  logic [2:0] code;

  always_comb
  begin
    fault = (pin_q[3] && !switch_supply_shutdown_control_q[cwt_pkg::SD_OV_BIT])
         || (pin_q[4] && !switch_supply_shutdown_control_q[cwt_pkg::SD_UV_BIT]);
    // without recovery the switches stay off until software rewrites them
    latch_d = latch_q;
    if (fault && !switch_supply_shutdown_control_q[cwt_pkg::SD_REC_BIT])
      latch_d = 1'b1;
    else if (hs_cfg_wr_i)
      latch_d = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      code = hs_cfg_i[s*cwt_pkg::HS_CODE_W +: cwt_pkg::HS_CODE_W];
      unique case (code)
        cwt_pkg::HS_ON:      demand[s] = 1'b1;
        cwt_pkg::HS_TIMER_A: demand[s] = tevt[0].level;
        cwt_pkg::HS_TIMER_B: demand[s] = tevt[1].level;
        cwt_pkg::HS_PWM_A:   demand[s] = pwm_i[0];
        cwt_pkg::HS_PWM_B:   demand[s] = pwm_i[1];
        default:             demand[s] = 1'b0;
      endcase
    end
    hs_d = (fault || latch_q) ? 4'h0 : demand;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hs_q    <= 4'h0;
      fault_q <= 1'b0;
      latch_q <= 1'b0;
    end
    else
    begin
      hs_q    <= hs_d;
      fault_q <= fault;
      latch_q <= latch_d;
    end
  end

  assign high_side_output_o = hs_q;
  assign supply_shutdown_o  = fault_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_fault_no_rec;
    fault && !switch_supply_shutdown_control_q[cwt_pkg::SD_REC_BIT] && !hs_cfg_wr_i;
  endsequence

  sequence s_fault_gone;
    !fault && !hs_cfg_wr_i;
  endsequence

  chk_filter_write: assert property (wr_filter && !soft_rst_i |=>
    wake_filter_select_q == ($past(reg_wdata_i) & 8'h3F))
    else $error("filter register write wrong");
  chk_timer_write: assert property (wr_timer_a && !soft_rst_i && !restart_clr[0] |=>
    cyclic_timer_a_control_q == ($past(reg_wdata_i) & 8'h77))
    else $error("timer register write wrong");
  chk_rsvd_read: assert property (reg_addr_i == cwt_pkg::ADDR_SHUTDOWN |=>
    reg_rdata_o[7] == 1'b0 && reg_rdata_o[3:0] == 4'h0)
    else $error("reserved bits read nonzero");
  chk_soft_reset: assert property (soft_rst_i |=> wake_filter_select_q == 8'h00
    && cyclic_timer_a_control_q == 8'h00 && cyclic_timer_b_control_q == 8'h00
    && switch_supply_shutdown_control_q == 8'h00)
    else $error("soft reset left a register set");
  chk_ov_shutdown: assert property (pin_q[3] && !switch_supply_shutdown_control_q[6]
    |=> high_side_output_o == 4'h0)
    else $error("switch on during overvoltage");
  chk_uv_shutdown: assert property (pin_q[4] && !switch_supply_shutdown_control_q[5]
    |=> high_side_output_o == 4'h0)
    else $error("switch on during undervoltage");
  chk_no_recovery: assert property (s_fault_no_rec ##1 s_fault_gone
    |=> high_side_output_o == 4'h0)
    else $error("switch recovered with recovery disabled");
  chk_recovery: assert property (fault_q && !fault && !latch_q
    |=> high_side_output_o == $past(demand))
    else $error("switch not restored after fault");
  chk_restart_clear: assert property (restart_mode_i && hs_clear_i && assigned[1]
    && !soft_rst_i |=> cyclic_timer_b_control_q == 8'h00)
    else $error("restart left timer settings");
  chk_timer_follow: assert property (!fault && !latch_q && hs_cfg_i[2:0] == 3'h2
    |=> high_side_output_o[0] == $past(tevt[0].level))
    else $error("switch not following timer a");
  chk_wake_concurrent: assert property (tevt[1].period_start && timer_wake_en_i[1]
    |=> timer_wake_o[1])
    else $error("cyclic wake missing");

endmodule

// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic        clk_i,
  // register port
  output logic             reg_wr_o,
  output logic      [6:0]  reg_addr_o,
  output logic      [7:0]  reg_wdata_o,
  input  wire logic [7:0]  reg_rdata_i,
  // switch configuration
  output logic      [11:0] hs_cfg_o,
  output logic             hs_cfg_wr_o
);
  initial
  begin
    reg_wr_o    = 1'b0;
    reg_addr_o  = 7'h00;
    reg_wdata_o = 8'h00;
    hs_cfg_o    = 12'h000;
    hs_cfg_wr_o = 1'b0;
  end
  // data is scrambled after the strobe so a stale value never looks valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask
  // read data lags the address by one edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
  // cyclic filters only work with their timer assigned to a switch
  task automatic set_hs(input logic [11:0] c);
    @(negedge clk_i);
    hs_cfg_o    = c;
    hs_cfg_wr_o = 1'b1;
    @(negedge clk_i);
    hs_cfg_wr_o = 1'b0;
  endtask
endmodule

// >>> tb_cyclic_sense_timer_wake_filter.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module tb_cyclic_sense_timer_wake_filter;
  // short tick keeps the run small; the meas expectations scale with it
  localparam int TK = 1;
  logic        clk_i = 1'b0;
  logic        rst_n_i, soft_rst_i, reg_wr_i, hs_cfg_wr_i, restart_mode_i, hs_clear_i;
  logic        supply_ov_i, supply_uv_i, supply_shutdown_o;
  logic [6:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o, rv;
  logic [11:0] hs_cfg_i;
  logic [1:0]  pwm_i, timer_wake_en_i, timer_level_o, timer_wake_o;
  logic [2:0]  wake_pin_i, wake_level_o;
  logic [3:0]  high_side_output_o;
  int          failures = 0;
  int          n_checks = 0;
  logic [6:0]  addr [4] = '{7'h09, 7'h0C, 7'h0D, 7'h10};
  logic [7:0]  mask [4] = '{8'h3F, 8'h77, 8'h77, 8'h70};
  int          on_t [5] = '{1, 3, 10, 100, 200};
  int          per_t [7] = '{100, 200, 500, 1000, 2000, 10000, 20000};
  logic [7:0]  stop_r [4] = '{8'h02, 8'h62, 8'h72, 8'h17};
  logic        stop_v [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0]  sd_r [4] = '{8'h40, 8'h10, 8'h30, 8'h00};
  logic        sd_o [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        sd_d [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic        sd_a [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  cyclic_sense_timer_wake_filter #(
    .TICK_CYCLES (TK)
  ) dut (
    .clk_i, .rst_n_i, .soft_rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .hs_cfg_i, .hs_cfg_wr_i, .pwm_i, .restart_mode_i, .hs_clear_i, .timer_wake_en_i,
    .wake_pin_i, .supply_ov_i, .supply_uv_i, .high_side_output_o, .timer_level_o,
    .timer_wake_o, .wake_level_o, .supply_shutdown_o
  );
  host_model host (
    .clk_i, .reg_wr_o (reg_wr_i), .reg_addr_o (reg_addr_i), .reg_wdata_o (reg_wdata_i),
    .reg_rdata_i (reg_rdata_o), .hs_cfg_o (hs_cfg_i), .hs_cfg_wr_o (hs_cfg_wr_i)
  );

  always #10 clk_i = ~clk_i;

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wait_rise(input int b, input int lim);
    int i;
    i = 0;
    while (timer_level_o[b] !== 1'b1 && i < lim)
    begin
      @(negedge clk_i);
      i++;
    end
    `CHK("timer_start", 1'b1, timer_level_o[b])
  endtask

  // stopping first clears the count so a shorter period can never wrap it
  task automatic run(input logic [2:0] on, input logic [2:0] per);
    host.wr(7'h0C, 8'h00);
    host.wr(7'h0C, {1'b0, on, 1'b0, per});
    wait_rise(0, 8000);
  endtask

  task automatic meas(input int b, input int cyc, input int ex_on, input int ex_wk);
    int th, hh, wk;
    th = 0;
    hh = 0;
    wk = 0;
    repeat (cyc)
    begin
      @(negedge clk_i);
      th += int'(timer_level_o[b] === 1'b1);
      hh += int'(high_side_output_o[b] === 1'b1);
      wk += int'(timer_wake_o[b] === 1'b1);
    end
    `CHK("timer_high", ex_on, th)
    `CHK("switch_high", ex_on, hh)
    `CHK("wake_pulses", ex_wk, wk)
  endtask

  task automatic wait_wake(input logic v);
    int i;
    i = 0;
    while (wake_level_o[2] !== v && i < 400)
    begin
      @(negedge clk_i);
      i++;
    end
    `CHK("wake_cyclic", v, wake_level_o[2])
  endtask

  initial
  begin
    #(60000 * 20);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    {rst_n_i, soft_rst_i, restart_mode_i, hs_clear_i, supply_ov_i, supply_uv_i} = 6'h00;
    pwm_i = 2'b00;
    timer_wake_en_i = 2'b00;
    wake_pin_i = 3'b000;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      host.rd(addr[i], rv);
      `CHK("reg_reset", 8'h00, rv)
      host.wr(addr[i], 8'hFF);
      host.rd(addr[i], rv);
      `CHK("reg_mask", mask[i], rv)
    end
    host.rd(7'h11, rv);
    `CHK("reg_unmapped", 8'h00, rv)
    soft_rst_i = 1'b1;
    @(negedge clk_i);
    soft_rst_i = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      host.rd(addr[i], rv);
      `CHK("reg_soft", 8'h00, rv)
    end
    host.set_hs(12'h05A);
    for (int i = 0; i < 7; i++)
    begin
      if (i < 5)
      begin
        run(3'(i + 1), 3'h2);
        meas(0, per_t[2] * TK, on_t[i] * TK, 0);
      end
      run(3'h1, 3'(i));
      meas(0, per_t[i] * TK, on_t[0] * TK, 0);
    end
    for (int i = 0; i < 4; i++)
    begin
      host.wr(7'h0C, stop_r[i]);
      repeat (300) @(negedge clk_i);
      `CHK("timer_stop", stop_v[i], timer_level_o[0])
      `CHK("switch_stop", stop_v[i], high_side_output_o[0])
    end
    host.set_hs(12'h042);
    host.wr(7'h0D, 8'h10);
    repeat (300) @(negedge clk_i);
    `CHK("timer_unassigned", 1'b0, timer_level_o[1])
    timer_wake_en_i = 2'b10;
    host.set_hs(12'h05A);
    wait_rise(1, 400);
    meas(1, 2 * per_t[0] * TK, 2 * on_t[0] * TK, 2);
    restart_mode_i = 1'b1;
    hs_clear_i = 1'b1;
    @(negedge clk_i);
    hs_clear_i = 1'b0;
    restart_mode_i = 1'b0;
    host.rd(7'h0C, rv);
    `CHK("restart_a", 8'h00, rv)
    host.rd(7'h0D, rv);
    `CHK("restart_b", 8'h00, rv)
    pwm_i = 2'b10;
    host.set_hs(12'hA5A);
    for (int i = 0; i < 4; i++)
    begin
      host.wr(7'h10, sd_r[i]);
      supply_ov_i = sd_o[i];
      supply_uv_i = ~sd_o[i];
      repeat (10) @(negedge clk_i);
      `CHK("switch_fault", {4{sd_d[i]}} & 4'hC, high_side_output_o)
      `CHK("fault_flag", ~sd_d[i], supply_shutdown_o)
      supply_ov_i = 1'b0;
      supply_uv_i = 1'b0;
      repeat (10) @(negedge clk_i);
      `CHK("switch_after", {4{sd_a[i]}} & 4'hC, high_side_output_o)
    end
    host.set_hs(12'hA5A);
    repeat (10) @(negedge clk_i);
    `CHK("switch_rewrite", 4'hC, high_side_output_o)
    host.wr(7'h09, 8'h24);
    wake_pin_i = 3'b111;
    repeat (700) @(negedge clk_i);
    `CHK("wake_a_early", 1'b0, wake_level_o[0])
    repeat (120) @(negedge clk_i);
    `CHK("wake_a", 1'b1, wake_level_o[0])
    repeat (2180) @(negedge clk_i);
    `CHK("wake_b_early", 1'b0, wake_level_o[1])
    repeat (250) @(negedge clk_i);
    `CHK("wake_b", 1'b1, wake_level_o[1])
    `CHK("wake_c_idle", 1'b0, wake_level_o[2])
    host.wr(7'h0C, 8'h10);
    wait_wake(1'b1);
    host.wr(7'h09, 8'h34);
    wake_pin_i = 3'b011;
    repeat (1000) @(negedge clk_i);
    `CHK("wake_c_hold", 1'b1, wake_level_o[2])
    host.wr(7'h0D, 8'h10);
    wait_wake(1'b0);
    tally_and_finish();
  end
endmodule
